// *** core/prbs_uut.sv ***
// Notes on behaviour
// - pattern polynomial x8+x6+x5+x4+1, eight stages
// - all eight stages preloaded with ones
// - preload when test request sent or received
// - frames end by fixed length, first bit flagged on bit_sof
// - pass needs table frame count for the tally, no framing error
// - generator state continues across frame boundaries
// - every frame carries same payload length
// - in test mode only hard reset counts
// - tester ends run with hard reset
// - more errors need more frames, per table
// - unit keeps running tally of bit errors
// - tally compared against allowed error totals
// - enough bits sent as minimum frame count
`timescale 1ns/10ps
`default_nettype none

module prbs_uut
	import prbs_bist_pkg::*;
#(
	parameter int PAYLOAD_BITS = TEST_PAYLOAD_LENGTH,
	parameter int BUF_W = 2,
	parameter int BUF_DEPTH = 2
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	prbs_link_if.uut_mp link,
	input wire logic TEST_REQ_I,
	input wire logic CHK_STALL_I,
	output logic TEST_MODE_O,
	output logic [TALLY_W-1:0] ERR_TALLY_O,
	output logic [FRAME_W-1:0] FRAMES_O,
	output logic FRAME_ERR_O,
	output logic PASS_O,
	output logic DONE_O
);

	localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CNT_W = $clog2(BUF_DEPTH + 1);

	typedef enum logic {U_IDLE, U_TEST} ustate_t;

	ustate_t state_reg, state_next;
	logic enter;
	logic leave;
	logic req_reg, req_next;
	logic mode_reg, mode_next;

	// buffer state
	logic [BUF_W-1:0] buf_reg [BUF_DEPTH];
	logic [BUF_W-1:0] buf_next [BUF_DEPTH];
	logic [PTR_W-1:0] wr_reg, wr_next;
	logic [PTR_W-1:0] rd_reg, rd_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic ready_reg, ready_next;
	logic push;
	logic pop;
	logic pop_bit;
	logic pop_sof;

	// checker state
	logic [7:0] lfsr_reg, lfsr_next;
	logic [15:0] pos_reg, pos_next;
	logic [TALLY_W-1:0] tally_reg, tally_next;
	logic [FRAME_W-1:0] frames_reg, frames_next;
	logic ferr_reg, ferr_next;
	logic pass_reg, pass_next;
	logic done_reg, done_next;

	////////////////////////////////////////////////////////////////
	// mode control
	// entry on own request or the tester's
	assign enter = (state_reg == U_IDLE) && (TEST_REQ_I || link.test_req);
	// only hard reset leaves test mode
	assign leave = (state_reg == U_TEST) && link.hard_reset;

	// mode next state
	always_comb begin
		state_next = state_reg;
		req_next = 1'b0;
		unique case (state_reg)
			U_IDLE: begin
				if (enter) begin
					state_next = U_TEST;
					req_next = TEST_REQ_I && !link.test_req;
				end
			end
			U_TEST: begin
				if (leave) begin
					state_next = U_IDLE;
				end
			end
		endcase
		mode_next = (state_next == U_TEST);
	end

	// mode registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			state_reg <= U_IDLE;
			req_reg <= 1'b0;
			mode_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			mode_reg <= mode_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// two-entry receive buffer, link side fills, checker drains
	assign push = link.bit_valid && ready_reg && (state_reg == U_TEST);
	assign pop = (cnt_reg != '0) && !CHK_STALL_I &&
		(state_reg == U_TEST) && !leave;
	assign pop_bit = buf_reg[rd_reg][0];
	assign pop_sof = buf_reg[rd_reg][1];

	// buffer next state
	always_comb begin
		buf_next = buf_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (enter || leave) begin
			// flushed at both ends of a run
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end else begin
			if (push) begin
				buf_next[wr_reg] = BUF_W'({link.bit_sof, link.bit_data});
				wr_next = (wr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 :
					wr_reg + 1'b1;
			end
			if (pop) begin
				rd_next = (rd_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 :
					rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_next = cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
		ready_next = (cnt_next < CNT_W'(BUF_DEPTH)) &&
			(state_next == U_TEST);
	end

	// buffer registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_reg[i] <= '0;
			end
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			buf_reg <= buf_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			ready_reg <= ready_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// pattern checker and error tally
	always_comb begin
		lfsr_next = lfsr_reg;
		pos_next = pos_reg;
		tally_next = tally_reg;
		frames_next = frames_reg;
		ferr_next = ferr_reg;
		pass_next = pass_reg;
		done_next = 1'b0;
		if (enter) begin
			lfsr_next = LFSR_PRELOAD;
			tally_next = '0;
			pos_next = 16'h0000;
			frames_next = '0;
			ferr_next = 1'b0;
			pass_next = 1'b0;
		end else if (pop) begin
			lfsr_next = lfsr_step(lfsr_reg);
			if (pop_bit != lfsr_reg[7] && tally_reg != '1) begin
				tally_next = tally_reg + 1'b1;
			end
			// frame marker must agree with length count
			if (pop_sof != (pos_reg == 16'h0000)) begin
				ferr_next = 1'b1;
			end
			if (pos_reg == 16'(PAYLOAD_BITS - 1)) begin
				pos_next = 16'h0000;
				if (frames_reg != '1) begin
					frames_next = frames_reg + 1'b1;
				end
			end else begin
				pos_next = pos_reg + 16'h0001;
			end
		end
		if (leave) begin
			pass_next = !ferr_reg &&
				(frames_for(16'(tally_reg)) != FRAMES_NONE) &&
				(16'(frames_reg) >= frames_for(16'(tally_reg)));
			done_next = 1'b1;
		end
	end

	// checker registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			lfsr_reg <= LFSR_PRELOAD;
			pos_reg <= 16'h0000;
			tally_reg <= '0;
			frames_reg <= '0;
			ferr_reg <= 1'b0;
			pass_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			lfsr_reg <= lfsr_next;
			pos_reg <= pos_next;
			tally_reg <= tally_next;
			frames_reg <= frames_next;
			ferr_reg <= ferr_next;
			pass_reg <= pass_next;
			done_reg <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all from registers
	assign link.uut_req = req_reg;
	assign link.bit_ready = ready_reg;
	assign TEST_MODE_O = mode_reg;
	assign ERR_TALLY_O = tally_reg;
	assign FRAMES_O = frames_reg;
	assign FRAME_ERR_O = ferr_reg;
	assign PASS_O = pass_reg;
	assign DONE_O = done_reg;

endmodule // prbs_uut

`default_nettype wire

// *** include/prbs_bist_pkg.sv ***
package prbs_bist_pkg;

	// generator / checker shift register
	localparam int LFSR_W = 8;
	localparam logic [7:0] LFSR_PRELOAD = 8'hff;

	// fixed payload length of one test frame, in bits
	localparam int TEST_PAYLOAD_LENGTH = 192;

	// counter widths
	localparam int FRAME_W = 16;
	localparam int TALLY_W = 16;
	localparam int SEL_W = 4;

	// allowed error totals and matching minimum frame counts
	localparam int TABLE_N = 13;
	localparam logic [15:0] ALLOWED_ERRS [TABLE_N] = '{
		16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
		16'h0006, 16'h0007, 16'h0008, 16'h000a, 16'h000f, 16'h0014,
		16'h001e};
	localparam logic [15:0] MIN_TEST_FRAME_COUNT [TABLE_N] = '{
		16'h1196, 16'h1953, 16'h2011, 16'h2652, 16'h2c45, 16'h3202,
		16'h3796, 16'h3d09, 16'h4263, 16'h4cd9, 16'h6605, 16'h7e48,
		16'had31};
	localparam logic [15:0] FRAMES_NONE = 16'hffff;

	// one step of x^8 + x^6 + x^5 + x^4 + 1, output is bit 7
	function automatic logic [7:0] lfsr_step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// least frame count that covers an error tally, all ones if none
	function automatic logic [15:0] frames_for(input logic [15:0] tally);
		logic [15:0] res;
		res = FRAMES_NONE;
		for (int i = TABLE_N - 1; i >= 0; i--) begin
			if (tally <= ALLOWED_ERRS[i]) begin
				res = MIN_TEST_FRAME_COUNT[i];
			end
		end
		return res;
	endfunction

endpackage

// *** include/prbs_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface prbs_link_if;
	logic test_req;   // tester asks to enter test mode, pulse
	logic uut_req;    // unit asks to enter test mode, pulse
	logic hard_reset; // hard-reset signalling, pulse
	logic bit_valid;  // payload bit offered
	logic bit_data;   // payload bit value
	logic bit_sof;    // first bit of a test frame
	logic bit_ready;  // unit can take a bit

	modport tester_mp (
		output test_req, hard_reset, bit_valid, bit_data, bit_sof,
		input uut_req, bit_ready
	);
	modport uut_mp (
		input test_req, hard_reset, bit_valid, bit_data, bit_sof,
		output uut_req, bit_ready
	);
endinterface // prbs_link_if

`default_nettype wire

// *** core/prbs_tester.sv ***
`timescale 1ns/10ps
`default_nettype none

module prbs_tester
	import prbs_bist_pkg::*;
#(
	parameter int PAYLOAD_BITS = TEST_PAYLOAD_LENGTH
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	prbs_link_if.tester_mp link,
	input wire logic START_I,
	input wire logic [SEL_W-1:0] ERR_SEL_I,
	input wire logic INJECT_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [FRAME_W-1:0] SENT_O
);

	typedef enum logic [1:0] {T_IDLE, T_SEND, T_HRST} tstate_t;

	tstate_t state_reg, state_next;
	logic [7:0] lfsr_reg, lfsr_next;
	logic [15:0] pos_reg, pos_next;
	logic [FRAME_W-1:0] sent_reg, sent_next;
	logic [FRAME_W-1:0] target_reg, target_next;
	logic req_reg, req_next;
	logic hrst_reg, hrst_next;
	logic valid_reg, valid_next;
	logic data_reg, data_next;
	logic sof_reg, sof_next;
	logic inj_reg, inj_next;
	logic done_reg, done_next;
	logic busy_reg, busy_next;
	logic take;

	assign take = valid_reg && link.bit_ready;

	////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb begin
		state_next = state_reg;
		lfsr_next = lfsr_reg;
		pos_next = pos_reg;
		sent_next = sent_reg;
		target_next = target_reg;
		req_next = 1'b0;
		hrst_next = 1'b0;
		valid_next = valid_reg;
		data_next = data_reg;
		sof_next = sof_reg;
		inj_next = inj_reg | INJECT_I;
		done_next = 1'b0;
		unique case (state_reg)
			T_IDLE: begin
				if (START_I || link.uut_req) begin
					if (ERR_SEL_I < SEL_W'(TABLE_N)) begin
						target_next = MIN_TEST_FRAME_COUNT[ERR_SEL_I];
					end else begin
						target_next = MIN_TEST_FRAME_COUNT[0];
					end
					// preload on request given or seen
					req_next = START_I && !link.uut_req;
					lfsr_next = LFSR_PRELOAD;
					pos_next = 16'h0000;
					sent_next = '0;
					valid_next = 1'b0;
					state_next = T_SEND;
				end
			end
			T_SEND: begin
				if (!valid_reg || take) begin
					if (take && pos_reg == 16'(PAYLOAD_BITS - 1)) begin
						sent_next = sent_reg + 1'b1;
					end
					if (take && pos_reg == 16'(PAYLOAD_BITS - 1) &&
						sent_reg + 1'b1 == target_reg) begin
						valid_next = 1'b0;
						state_next = T_HRST;
					end else begin
						data_next = lfsr_reg[7] ^ inj_next;
						inj_next = 1'b0;
						lfsr_next = lfsr_step(lfsr_reg);
						// boundary by fixed length, first bit flagged on bit_sof
						sof_next = (pos_next == 16'h0000);
						valid_next = 1'b1;
					end
				end
				if (take) begin
					if (pos_reg == 16'(PAYLOAD_BITS - 1)) begin
						pos_next = 16'h0000;
					end else begin
						pos_next = pos_reg + 16'h0001;
					end
					if (state_next == T_SEND) begin
						sof_next = (pos_next == 16'h0000);
					end
				end
			end
			T_HRST: begin
				hrst_next = 1'b1;
				done_next = 1'b1;
				state_next = T_IDLE;
			end
		endcase
		// busy flag registered so the output comes from a flip-flop
		busy_next = (state_next != T_IDLE);
	end

	// sequencer registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			state_reg <= T_IDLE;
			lfsr_reg <= LFSR_PRELOAD;
			pos_reg <= 16'h0000;
			sent_reg <= '0;
			target_reg <= '0;
			req_reg <= 1'b0;
			hrst_reg <= 1'b0;
			valid_reg <= 1'b0;
			data_reg <= 1'b0;
			sof_reg <= 1'b0;
			inj_reg <= 1'b0;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			lfsr_reg <= lfsr_next;
			pos_reg <= pos_next;
			sent_reg <= sent_next;
			target_reg <= target_next;
			req_reg <= req_next;
			hrst_reg <= hrst_next;
			valid_reg <= valid_next;
			data_reg <= data_next;
			sof_reg <= sof_next;
			inj_reg <= inj_next;
			done_reg <= done_next;
			busy_reg <= busy_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign link.test_req = req_reg;
	assign link.hard_reset = hrst_reg;
	assign link.bit_valid = valid_reg;
	assign link.bit_data = data_reg;
	assign link.bit_sof = sof_reg;
	assign BUSY_O = busy_reg;
	assign DONE_O = done_reg;
	assign SENT_O = sent_reg;

endmodule // prbs_tester

`default_nettype wire

// *** sim/prbs_bist_frame_engine_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module prbs_bist_frame_engine_checker #(
	parameter int PAYLOAD_BITS = 192
) (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic test_req,
	input wire logic uut_req,
	input wire logic hard_reset,
	input wire logic bit_valid,
	input wire logic bit_data,
	input wire logic bit_sof,
	input wire logic bit_ready
);
	logic [15:0] pos_reg;
	wire logic take = bit_valid && bit_ready;

	////////////////////////////////////////////////////////////////////////
	// position of the next bit inside its frame, restarted by any request
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || test_req || uut_req) begin
			pos_reg <= 16'h0000;
		end else if (take) begin
			pos_reg <= (pos_reg == 16'(PAYLOAD_BITS - 1)) ? 16'h0000 :
				pos_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	// first bit after a preload of all ones
	sequence first_bit;
		bit_valid && bit_sof && bit_data;
	endsequence

	// link stays silent after the exit signalling
	sequence quiet_link;
		!bit_valid [*3];
	endsequence

	a_req_pulse: assert property (test_req |=> !test_req)
		else $error("test request longer than one cycle");
	a_first_bit: assert property (test_req |=> bit_ready ##0 first_bit)
		else $error("first bit after request wrong");
	a_peer_start: assert property (uut_req |-> ##[1:3] first_bit)
		else $error("no pattern after unit request");
	a_bit_held: assert property (bit_valid && !bit_ready |=>
		bit_valid && $stable({bit_data, bit_sof}))
		else $error("offered bit changed before taken");
	a_sof_frame: assert property (take |-> bit_sof == (pos_reg == 16'h0000))
		else $error("frame start off fixed length");
	a_no_req_test: assert property (bit_valid |-> !test_req && !uut_req)
		else $error("request while in test mode");
	a_end_quiet: assert property (hard_reset |-> !bit_valid && !$past(bit_valid))
		else $error("hard reset while bits offered");
	a_exit_quiet: assert property (hard_reset |=> quiet_link)
		else $error("bits after hard reset");
	a_ready_drop: assert property (hard_reset |-> ##[1:2] !bit_ready)
		else $error("unit still ready after hard reset");
	a_hr_pulse: assert property (hard_reset |=> !hard_reset)
		else $error("hard reset longer than one cycle");

endmodule // prbs_bist_frame_engine_checker

`default_nettype wire

// *** sim/prbs_bist_frame_engine_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module prbs_bist_frame_engine_test import prbs_bist_pkg::*;;
	// short frame, prime to the 255-bit pattern cycle, keeps runs brief
	localparam int PB = 2;
	// four runs of about 9000 to 13000 cycles each, with margin
	localparam int LIMIT = 60000;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, inj = 1'b0, treq = 1'b0;
	logic stall = 1'b0, stall_en = 1'b0;
	logic [3:0] sel = 4'h0;
	logic busy, tdone, udone, tmode, ferr, pass;
	logic [15:0] sent, tally, frames;
	logic [7:0] model = 8'hff;
	int bad_count = 0, n_tests = 0, cyc = 0, wire_err = 0, bitpos = 0;

	prbs_link_if lnk();
	prbs_tester #(.PAYLOAD_BITS(PB)) prbs_tester_i (.REF_CLK_I(clk),
		.RST_I(rst), .link(lnk), .START_I(start), .ERR_SEL_I(sel),
		.INJECT_I(inj), .BUSY_O(busy), .DONE_O(tdone), .SENT_O(sent));
	prbs_uut #(.PAYLOAD_BITS(PB)) prbs_uut_i (.REF_CLK_I(clk), .RST_I(rst),
		.link(lnk), .TEST_REQ_I(treq), .CHK_STALL_I(stall),
		.TEST_MODE_O(tmode), .ERR_TALLY_O(tally), .FRAMES_O(frames),
		.FRAME_ERR_O(ferr), .PASS_O(pass), .DONE_O(udone));
	prbs_bist_frame_engine_checker #(.PAYLOAD_BITS(PB))
		prbs_bist_frame_engine_checker_i (.REF_CLK_I(clk), .RST_I(rst),
		.test_req(lnk.test_req), .uut_req(lnk.uut_req),
		.hard_reset(lnk.hard_reset), .bit_valid(lnk.bit_valid),
		.bit_data(lnk.bit_data), .bit_sof(lnk.bit_sof),
		.bit_ready(lnk.bit_ready));

	////////////////////////////////////////////////////////////////////////
	// clock generation
	initial begin
		forever #20 clk = ~clk;
	end

	// compare tasks and closing report
	task automatic chk1(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// frames the tester sends for selection 0, 1 or one beyond the table
	function automatic logic [15:0] frames_of(input logic [3:0] s);
		return (s == 4'h1) ? 16'h1953 : 16'h1196;
	endfunction

	// verdict: frames sent must cover the tally
	function automatic logic pass_of(input logic [3:0] s, input int n);
		logic [15:0] need;
		need = (n == 0) ? 16'h1196 : (n == 1) ? 16'h1953 : 16'hffff;
		return frames_of(s) >= need;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// wire monitor with its own pattern model, random stall, timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc > LIMIT) begin
			bad_count++;
			finish_test();
		end
		if (lnk.test_req || lnk.uut_req) begin
			model = 8'hff;
			bitpos = 0;
			wire_err = 0;
		end else if (lnk.bit_valid && lnk.bit_ready) begin
			if (lnk.bit_data !== model[7]) begin
				wire_err++;
			end
			chk1("frame start", bitpos == 0, lnk.bit_sof);
			model = {model[6:0], model[7] ^ model[5] ^ model[4] ^ model[3]};
			bitpos = (bitpos == PB - 1) ? 0 : bitpos + 1;
		end
		stall <= stall_en && sent < 16'h0fa0 && $urandom_range(3) == 0;
	end

	// one test run, with refused requests and injected errors mid-run
	task automatic run(input logic by_uut, input logic [3:0] s, input int n,
		input logic st);
		@(posedge clk);
		sel <= s;
		stall_en <= st;
		if (by_uut) begin
			treq <= 1'b1;
		end else begin
			start <= 1'b1;
		end
		@(posedge clk);
		treq <= 1'b0;
		start <= 1'b0;
		repeat (3) @(negedge clk);
		chk1("test mode", 1'b1, tmode);
		chk1("tester busy", 1'b1, busy);
		chk16("tally at entry", 16'h0000, tally);
		for (int k = 0; k < n; k++) begin
			repeat ($urandom_range(600, 100)) @(posedge clk);
			inj <= 1'b1;
			treq <= 1'b1;
			start <= 1'b1;
			@(posedge clk);
			inj <= 1'b0;
			treq <= 1'b0;
			start <= 1'b0;
		end
		do @(negedge clk); while (tdone !== 1'b1);
		chk1("hard reset with done", 1'b1, lnk.hard_reset);
		chk1("tester busy", 1'b0, busy);
		@(negedge clk);
		chk1("unit done", 1'b1, udone);
		chk1("test mode", 1'b0, tmode);
		chk16("tally", 16'(n), tally);
		chk16("wire errors", 16'(n), 16'(wire_err));
		chk16("frames", frames_of(s), frames);
		chk16("sent", frames_of(s), sent);
		chk1("framing", 1'b0, ferr);
		chk1("verdict", pass_of(s, n), pass);
		repeat (10) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'h47fd));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk1("mode at reset", 1'b0, tmode);
		chk16("tally at reset", 16'h0000, tally);
		run(1'b0, 4'h0, 0, 1'b1);
		run(1'b1, 4'h1, 1, 1'b0);
		run(1'b0, 4'h0, 1, 1'b0);
		// selection beyond the table falls back to the shortest run
		run(1'b1, 4'hd, 0, 1'b0);
		finish_test();
	end

endmodule // prbs_bist_frame_engine_test

`default_nettype wire
